// ===== inc/aicd_pkg.sv
// Shared constants and types of the input configuration decoder.
package aicd_pkg;

    // -------------------------------------------------------------------
    // Word widths
    // -------------------------------------------------------------------
    localparam int unsigned CFG_W = 14;
    localparam int unsigned RES_W = 16;

    // -------------------------------------------------------------------
    // Register byte offsets on the bus
    // -------------------------------------------------------------------
    localparam logic [7:0] ADR_CFG    = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_RESULT = 8'h08;

    // -------------------------------------------------------------------
    // Configuration word fields, status busy bit and reset value
    // -------------------------------------------------------------------
    localparam int unsigned ARR_HI  = 12;
    localparam int unsigned ARR_LO  = 10;
    localparam int unsigned CHAN_HI = 9;
    localparam int unsigned CHAN_LO = 7;
    localparam int unsigned BW_BIT  = 6;
    localparam int unsigned BUSY_BIT = 16;
    localparam logic [13:0] CFG_RESET = 14'h1C40;

    // Arrangement field codes; pair codes name only the upper two bits.
    localparam logic [2:0] ARR_CODE_SE  = 3'h7;
    localparam logic [2:0] ARR_CODE_CBI = 3'h2;
    localparam logic [2:0] ARR_CODE_CUN = 3'h6;
    localparam logic [1:0] ARR_CODE_PBI = 2'h0;
    localparam logic [1:0] ARR_CODE_PUN = 2'h2;

    // -------------------------------------------------------------------
    // Result codes
    // -------------------------------------------------------------------
    localparam logic [15:0] UNI_MAX   = 16'hFFFF;
    localparam logic [15:0] UNI_MIN   = 16'h0000;
    localparam logic [15:0] BI_MAX    = 16'h7FFF;
    localparam logic [15:0] BI_MIN    = 16'h8000;
    localparam logic [15:0] MIDSCALE  = 16'h8000;

    // -------------------------------------------------------------------
    // Types
    // -------------------------------------------------------------------
    typedef enum logic [4:0] {
        ARR_SINGLE   = 5'b00001,
        ARR_COM_BIP  = 5'b00010,
        ARR_COM_UNI  = 5'b00100,
        ARR_PAIR_BIP = 5'b01000,
        ARR_PAIR_UNI = 5'b10000
    } aicd_arr_t;

    typedef enum logic [2:0] {
        NEG_GND = 3'b001,
        NEG_COM = 3'b010,
        NEG_PIN = 3'b100
    } aicd_neg_t;

    typedef enum logic [1:0] {
        ST_ACQUIRE = 2'b01,
        ST_CONVERT = 2'b10
    } aicd_state_t;

    typedef struct packed {
        aicd_arr_t  arr;
        logic       bipolar;
        logic [2:0] positive_input;
        aicd_neg_t  neg_kind;
        logic [2:0] negative_input;
        logic       full_bw;
    } aicd_route_t;

    typedef struct packed {
        logic        over;
        logic        under;
        logic [15:0] code;
    } aicd_raw_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } aicd_wb_req_t;

endpackage : aicd_pkg

// ===== design/aicd_route_decode.sv
// Decoder from configuration word to multiplexer routing.
`timescale 1ns/10ps
`default_nettype none
module aicd_route_decode (
    input  wire logic [13:0]         cfg_i,
    input  wire logic                seq_scan_i,
    output aicd_pkg::aicd_route_t    route_o
);
    import aicd_pkg::*;

    // -------------------------------------------------------------------
    // Field decoding
    // -------------------------------------------------------------------
    // Unlisted code 011 falls to bipolar common so every code routes.
    function automatic aicd_arr_t arr_of(input logic [2:0] f);
        aicd_arr_t a;
        a = ARR_COM_BIP;
        if (f == ARR_CODE_SE) begin
            a = ARR_SINGLE;
        end else if (f == ARR_CODE_CUN) begin
            a = ARR_COM_UNI;
        end else if (f[2:1] == ARR_CODE_PBI) begin
            a = ARR_PAIR_BIP;
        end else if (f[2:1] == ARR_CODE_PUN) begin
            a = ARR_PAIR_UNI;
        end
        return a;
    endfunction : arr_of

    wire aicd_arr_t  arr    = arr_of(cfg_i[ARR_HI:ARR_LO]);
    wire logic [2:0] chan   = cfg_i[CHAN_HI:CHAN_LO];
    wire logic       is_pair = (arr == ARR_PAIR_BIP) ||
                               (arr == ARR_PAIR_UNI);
    // The sequencer scans pairs with the even input as positive.
    wire logic [2:0] pos    = (is_pair && seq_scan_i) ?
                              {chan[2:1], 1'b0} : chan;

    // Route assembly; a pair's negative member is the partner input.
    assign route_o.arr            = arr;
    assign route_o.bipolar        = (arr == ARR_COM_BIP) ||
                                    (arr == ARR_PAIR_BIP);
    assign route_o.positive_input = pos;
    assign route_o.neg_kind       = is_pair ? NEG_PIN :
                                    (arr == ARR_SINGLE) ? NEG_GND : NEG_COM;
    assign route_o.negative_input = is_pair ? (pos ^ 3'h1) : 3'h0;
    assign route_o.full_bw        = cfg_i[BW_BIT];

endmodule : aicd_route_decode
`default_nettype wire

// ===== design/aicd_result_coder.sv
// Output coding and clamping of one conversion result.
`timescale 1ns/10ps
`default_nettype none
module aicd_result_coder (
    input  wire aicd_pkg::aicd_raw_t raw_i,
    input  wire logic                bipolar_i,
    output logic [15:0]              code_o
);
    import aicd_pkg::*;

    // -------------------------------------------------------------------
    // Coding
    // -------------------------------------------------------------------
    // The core delivers offset binary, so straight binary is the raw code
    // and twos complement is the raw code with its sign bit turned over.
    wire logic [15:0] hi_code  = bipolar_i ? BI_MAX : UNI_MAX;
    wire logic [15:0] lo_code  = bipolar_i ? BI_MIN : UNI_MIN;
    wire logic [15:0] lin_code = bipolar_i ? (raw_i.code ^ MIDSCALE)
                                           : raw_i.code;

    // Over-range wins if the core ever flags both at once.
    assign code_o = raw_i.over  ? hi_code :
                    raw_i.under ? lo_code : lin_code;

endmodule : aicd_result_coder
`default_nettype wire

// ===== design/aicd_config_core.sv
// Input configuration decoder with result coding and bus registers.
`timescale 1ns/10ps
`default_nettype none
module aicd_config_core (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 ce_i,
    input  wire aicd_pkg::aicd_wb_req_t wb_req_i,
    output logic [31:0]               wb_dat_o,
    output logic                      wb_ack_o,
    input  wire logic                 conversion_trigger_i,
    input  wire logic                 seq_scan_i,
    input  wire logic                 raw_valid_i,
    input  wire aicd_pkg::aicd_raw_t  raw_i,
    output aicd_pkg::aicd_route_t     route_o,
    output logic                      filter_bandwidth_sel_o,
    output logic                      busy_o,
    output logic [15:0]               result_o,
    output logic                      result_valid_o
);
    import aicd_pkg::*;

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    logic [13:0]  cfg;
    aicd_route_t  route_act;
    aicd_state_t  state;
    logic [15:0]  result;
    logic         result_valid;
    logic         ack;
    logic [31:0]  rd_data;
    logic         trig_s1;
    logic         trig_s2;
    logic         trig_s3;
    logic         trig_level;

    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    // The write lands on the edge where the master sees the answer.
    wire logic req       = wb_req_i.cyc & wb_req_i.stb;
    wire logic hit_cfg   = (wb_req_i.adr == ADR_CFG);
    wire logic hit_stat  = (wb_req_i.adr == ADR_STATUS);
    wire logic hit_res   = (wb_req_i.adr == ADR_RESULT);
    wire logic cfg_write = req & wb_req_i.we & ack & hit_cfg;
    wire logic [31:0] status_word = {15'h0000, busy_o, route_act};

    // Unmapped offsets answer normally and read as zero.
    wire logic [31:0] rd_mux =
        hit_cfg  ? {18'h00000, cfg} :
        hit_stat ? status_word :
        hit_res  ? {16'h0000, result} : 32'h0000_0000;

    // Byte lanes of the configuration word; bits above 13 are dropped.
    logic [13:0] next_cfg;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lane
            localparam int unsigned LO = 8 * g;
            localparam int unsigned HI = (g == 0) ? 7 : 13;
            assign next_cfg[HI:LO] = (cfg_write && wb_req_i.sel[g]) ?
                                     wb_req_i.dat[HI:LO] : cfg[HI:LO];
        end
    endgenerate

    // -------------------------------------------------------------------
    // Bus slave registers
    // -------------------------------------------------------------------
    // Ack rises one edge after the request and drops the edge after.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack     <= 1'b0;
            rd_data <= 32'h0000_0000;
            cfg     <= CFG_RESET;
        end else if (ce_i) begin
            ack     <= req & ~ack;
            rd_data <= rd_mux;
            cfg     <= next_cfg;
        end
    end

    assign wb_ack_o = ack;
    assign wb_dat_o = rd_data;

    // -------------------------------------------------------------------
    // Trigger pin synchroniser
    // -------------------------------------------------------------------
    // The pin is asynchronous; a change counts once the last two agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_s1    <= 1'b0;
            trig_s2    <= 1'b0;
            trig_s3    <= 1'b0;
            trig_level <= 1'b0;
        end else if (ce_i) begin
            trig_s1 <= conversion_trigger_i;
            trig_s2 <= trig_s1;
            trig_s3 <= trig_s2;
            if (trig_s2 == trig_s3) begin
                trig_level <= trig_s3;
            end
        end
    end

    wire logic trig_rise = trig_s2 & trig_s3 & ~trig_level;

    // -------------------------------------------------------------------
    // Routing and coding
    // -------------------------------------------------------------------
    aicd_route_t route_new;
    logic [15:0] coded;

    aicd_route_decode u_decode (
        .cfg_i      (cfg),
        .seq_scan_i (seq_scan_i),
        .route_o    (route_new)
    );

    // Coding uses the latched route, never the live register.
    aicd_result_coder u_coder (
        .raw_i     (raw_i),
        .bipolar_i (route_act.bipolar),
        .code_o    (coded)
    );

    wire logic capture = ce_i & (state == ST_ACQUIRE) & trig_rise;
    wire logic finish  = ce_i & (state == ST_CONVERT) & raw_valid_i;

    // -------------------------------------------------------------------
    // Conversion sequence
    // -------------------------------------------------------------------
    // A trigger during a conversion is ignored; the arrangement is taken
    // afresh at every trigger, so any mix of arrangements is allowed.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_ACQUIRE;
        end else if (ce_i) begin
            unique case (state)
                ST_ACQUIRE: begin
                    if (trig_rise) begin
                        state <= ST_CONVERT;
                    end
                end
                ST_CONVERT: begin
                    if (raw_valid_i) begin
                        state <= ST_ACQUIRE;
                    end
                end
                default: begin
                    state <= ST_ACQUIRE;
                end
            endcase
        end
    end

    // Route latch; the reset route is the decode of the reset word.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            route_act <= '{arr: ARR_SINGLE, bipolar: 1'b0,
                           positive_input: 3'h0, neg_kind: NEG_GND,
                           negative_input: 3'h0, full_bw: 1'b1};
        end else if (capture) begin
            route_act <= route_new;
        end
    end

    // Result register and its one-cycle valid strobe.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            result       <= 16'h0000;
            result_valid <= 1'b0;
        end else if (ce_i) begin
            result_valid <= raw_valid_i & (state == ST_CONVERT);
            if (finish) begin
                result <= coded;
            end
        end
    end

    assign route_o                = route_act;
    assign filter_bandwidth_sel_o = route_act.full_bw;
    assign busy_o                 = (state == ST_CONVERT);
    assign result_o               = result;
    assign result_valid_o         = result_valid;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    uni_linear_a : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && !route_act.bipolar && !raw_i.over && !raw_i.under
        |=> result_o == $past(raw_i.code))
        else $error("unipolar code not straight binary");

    bi_linear_a : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && route_act.bipolar && !raw_i.over && !raw_i.under
        |=> result_o == ($past(raw_i.code) ^ 16'h8000))
        else $error("bipolar code not twos complement");

    over_clamp_a : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && raw_i.over
        |=> result_o == ($past(route_act.bipolar) ? 16'h7FFF : 16'hFFFF))
        else $error("over-range not clamped");

    under_clamp_a : assert property (@(posedge clk_i) disable iff (rst_i)
        finish && raw_i.under && !raw_i.over
        |=> result_o == ($past(route_act.bipolar) ? 16'h8000 : 16'h0000))
        else $error("under-range not clamped");

    bw_select_a : assert property (@(posedge clk_i) disable iff (rst_i)
        capture |=> filter_bandwidth_sel_o == $past(cfg[6]))
        else $error("bandwidth select not taken from bit 6");

    single_ended_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        capture && cfg[12:10] == 3'h7
        |=> route_o.arr == ARR_SINGLE && route_o.neg_kind == NEG_GND)
        else $error("code 111 not single-ended");

    common_mode_a : assert property (@(posedge clk_i) disable iff (rst_i)
        capture && (cfg[12:10] == 3'h2 || cfg[12:10] == 3'h6)
        |=> route_o.neg_kind == NEG_COM
            && route_o.bipolar == !$past(cfg[12]))
        else $error("common arrangement decoded wrongly");

    pair_mode_a : assert property (@(posedge clk_i) disable iff (rst_i)
        capture && cfg[11] == 1'b0 && cfg[10:10] inside {1'b0, 1'b1}
        && cfg[12:11] != 2'h1
        |=> route_o.neg_kind == NEG_PIN
            && route_o.bipolar == !$past(cfg[12]))
        else $error("pair arrangement decoded wrongly");

    pair_parity_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        capture && cfg[11] == 1'b0 && !seq_scan_i
        |=> route_o.positive_input == $past(cfg[9:7])
            && route_o.negative_input == ($past(cfg[9:7]) ^ 3'h1))
        else $error("pair members not taken from channel field");

    seq_even_a : assert property (@(posedge clk_i) disable iff (rst_i)
        capture && cfg[11] == 1'b0 && seq_scan_i
        |=> route_o.positive_input[0] == 1'b0
            && route_o.negative_input[0] == 1'b1)
        else $error("sequencer pair not even-positive");

    route_hold_a : assert property (@(posedge clk_i) disable iff (rst_i)
        busy_o |=> $stable(route_act))
        else $error("route changed during conversion");

    cfg_write_a : assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && cfg_write && wb_req_i.sel[1:0] == 2'h3
        |=> cfg == $past(wb_req_i.dat[13:0]))
        else $error("configuration word not written");

    ack_pulse_a : assert property (@(posedge clk_i) disable iff (rst_i)
        ce_i && wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    // -------------------------------------------------------------------
    // Sequencing, holding, routing and bus timing checks
    // -------------------------------------------------------------------
    // A slip of one edge shows up here rather than as a bad code later.
    busy_start_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        capture |=> busy_o && route_act == $past(route_new))
        else $error("trigger did not start a conversion");

    busy_end_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        finish |=> !busy_o && result_valid_o)
        else $error("finished conversion not reported");

    valid_quiet_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !finish |=> !result_valid_o)
        else $error("result valid without a finished conversion");

    result_hold_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        !finish |=> $stable(result_o))
        else $error("result changed outside a finish");

    conv_hold_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        busy_o && !finish |=> busy_o)
        else $error("conversion ended without a core answer");

    idle_hold_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        !busy_o && !capture |=> !busy_o)
        else $error("conversion started without a trigger");

    bw_hold_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        busy_o |=> $stable(filter_bandwidth_sel_o))
        else $error("bandwidth changed during conversion");

    pair_neg_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        capture && !cfg[11]
        |=> route_o.neg_kind == NEG_PIN
            && route_o.negative_input == (route_o.positive_input ^ 3'h1))
        else $error("pair partner not the adjacent input");

    plain_route_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        capture && cfg[11]
        |=> route_o.positive_input == $past(cfg[9:7])
            && route_o.negative_input == 3'h0)
        else $error("non-pair route not taken from channel field");

    ack_answer_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && req && !ack |=> wb_ack_o)
        else $error("request not answered in the next cycle");

    ack_idle_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !req |=> !wb_ack_o)
        else $error("ack without a request");

    cfg_read_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && req && !wb_req_i.we && hit_cfg
        |=> wb_dat_o == {18'h0, $past(cfg)})
        else $error("configuration word read back wrongly");

    cfg_keep_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        !cfg_write |=> $stable(cfg))
        else $error("configuration word changed without a write");

    ce_freeze_a : assert property (@(posedge clk_i)
        disable iff (rst_i)
        !ce_i |=> $stable(state) && $stable(wb_ack_o) && $stable(trig_s3))
        else $error("state moved while clock enable was low");

endmodule : aicd_config_core
`default_nettype wire

// ===== sim/aicd_core_model.sv
// Behavioural converter core that answers each started conversion.
`timescale 1ns/10ps
`default_nettype none
module aicd_core_model (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                busy_i,
    input  wire logic [3:0]          dly_i,
    input  wire aicd_pkg::aicd_raw_t raw_set_i,
    output logic                     raw_valid_o,
    output aicd_pkg::aicd_raw_t      raw_o
);
    import aicd_pkg::*;

    logic [4:0] cnt;
    logic       armed;

    // Lines start quiet so the core sees no unknown before reset.
    initial begin
        raw_valid_o = 1'b0;
        raw_o       = '0;
    end

    // One answer per busy period; the data toggles outside the answer
    // cycle so that a stale sample can never look like a good one.
    always @(posedge clk_i) begin
        raw_valid_o <= 1'b0;
        raw_o       <= ~raw_o;
        if (rst_i) begin
            armed <= 1'b0;
        end else if (!busy_i) begin
            armed <= 1'b0;
        end else if (!armed) begin
            armed <= 1'b1;
            cnt   <= {1'b0, dly_i};
        end else if (cnt == 5'h00) begin
            raw_valid_o <= 1'b1;
            raw_o       <= raw_set_i;
            cnt         <= 5'h1F;
        end else if (cnt != 5'h1F) begin
            cnt <= cnt - 5'h01;
        end
    end
endmodule : aicd_core_model
`default_nettype wire

// ===== sim/aicd_config_core_test.sv
// Self-checking bench of the input configuration decoder.
`timescale 1ns/10ps
`default_nettype none
module aicd_config_core_test;
    import aicd_pkg::*;

    logic         clk_i = 1'b0;
    logic         rst_i = 1'b1;
    aicd_wb_req_t wb_req = '0;
    logic [31:0]  wb_dat_o;
    logic         wb_ack_o;
    logic         trig = 1'b0;
    logic         ce = 1'b1;
    logic         seq = 1'b0;
    logic         raw_valid;
    aicd_raw_t    raw;
    aicd_raw_t    raw_set = '0;
    logic [3:0]   dly = 4'h0;
    aicd_route_t  route_o;
    logic         bw_o;
    logic         busy_o;
    logic         res_v;
    logic [15:0]  result_o;
    logic [31:0]  rd;
    int           failures = 0;
    int           n_tests = 0;
    int           cycles = 0;

    always #50 clk_i = ~clk_i;

    aicd_config_core aicd_config_core_inst (
        .clk_i                  (clk_i),
        .rst_i                  (rst_i),
        .ce_i                   (ce),
        .wb_req_i               (wb_req),
        .wb_dat_o               (wb_dat_o),
        .wb_ack_o               (wb_ack_o),
        .conversion_trigger_i   (trig),
        .seq_scan_i             (seq),
        .raw_valid_i            (raw_valid),
        .raw_i                  (raw),
        .route_o                (route_o),
        .filter_bandwidth_sel_o (bw_o),
        .busy_o                 (busy_o),
        .result_o               (result_o),
        .result_valid_o         (res_v)
    );

    aicd_core_model aicd_core_model_inst (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .busy_i      (busy_o),
        .dly_i       (dly),
        .raw_set_i   (raw_set),
        .raw_valid_o (raw_valid),
        .raw_o       (raw)
    );

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // A hung handshake must still reach the closing report.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end

    // One classic cycle: hold everything until ack is sampled high.
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_req <= '{cyc:1'b1, stb:1'b1, we:we, sel:4'hF, adr:a, dat:d};
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        wb_req <= '0;
        check({31'h0, wb_ack_o}, 32'h1);
    endtask : wb

    // Expected route in the packed layout, bit 16 left for busy.
    function automatic logic [16:0] exp_route(logic [13:0] c, logic s);
        aicd_route_t r;
        logic        pair;
        r = '0;
        pair = !c[11];
        casez (c[12:10])
            3'b111:  r.arr = ARR_SINGLE;
            3'b110:  r.arr = ARR_COM_UNI;
            3'b01?:  r.arr = ARR_COM_BIP;
            3'b00?:  r.arr = ARR_PAIR_BIP;
            default: r.arr = ARR_PAIR_UNI;
        endcase
        r.bipolar = !c[12];
        r.full_bw = c[6];
        r.positive_input = c[9:7];
        if (pair && s)
            r.positive_input = {c[9:8], 1'b0};
        r.negative_input = r.positive_input ^ 3'h1;
        if (pair)
            r.neg_kind = NEG_PIN;
        else if (c[12:10] == 3'b111)
            r.neg_kind = NEG_GND;
        else
            r.neg_kind = NEG_COM;
        return {1'b0, r};
    endfunction : exp_route

    function automatic logic [15:0] exp_code(aicd_raw_t w, logic b);
        if (w.over)
            return b ? BI_MAX : UNI_MAX;
        if (w.under)
            return b ? BI_MIN : UNI_MIN;
        return b ? (w.code ^ MIDSCALE) : w.code;
    endfunction : exp_code

    // Non-pair arrangements leave the negative input number open.
    task automatic convert(input logic [13:0] c, input logic mid);
        logic [16:0] e;
        logic [16:0] m;
        int          n;
        e = exp_route(c, seq);
        m = c[11] ? 17'h1FFF1 : 17'h1FFFF;
        wb(1'b1, ADR_CFG, {18'h0, c}, rd);
        trig <= 1'b1;
        n = 0;
        while (busy_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        trig <= 1'b0;
        check({31'h0, busy_o}, 32'h1);
        check({15'h0, {1'b0, route_o} & m},
              {15'h0, e & m});
        check({31'h0, bw_o}, {31'h0, c[6]});
        if (mid) begin
            wb(1'b0, ADR_STATUS, 32'h0, rd);
            check({15'h0, rd[16:0] & m}, {15'h0, (e & m) | 17'h10000});
            wb(1'b1, ADR_CFG, {18'h0, c ^ 14'h1000}, rd);
        end
        n = 0;
        while (res_v !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        check({31'h0, res_v}, 32'h1);
        check({16'h0, result_o},
              {16'h0, exp_code(raw_set, !c[12])});
        wb(1'b0, ADR_RESULT, 32'h0, rd);
        check(rd, {16'h0, exp_code(raw_set, !c[12])});
        repeat (c[6] ? 6 : 24) @(posedge clk_i);
    endtask : convert

    // Reset state, register access, then mixed conversions.
    initial begin
        logic [13:0] c;
        logic [31:0] d;
        void'($urandom(32'hA10B));
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        check({15'h0, {1'b0, route_o} & 17'h1FFF1},
              {15'h0, exp_route(CFG_RESET, 1'b0) & 17'h1FFF1});
        check({31'h0, bw_o}, 32'h1);
        wb(1'b0, ADR_CFG, 32'h0, rd);
        check(rd, {18'h0, CFG_RESET});
        d = $urandom;
        wb(1'b1, ADR_CFG, d, rd);
        wb(1'b1, ADR_RESULT, ~d, rd);
        // A low clock enable must hold the answer back.
        ce <= 1'b0;
        fork
            wb(1'b0, ADR_CFG, 32'h0, rd);
            begin
                repeat (4) begin
                    @(posedge clk_i);
                    check({31'h0, wb_ack_o}, 32'h0);
                end
                ce <= 1'b1;
            end
        join
        check(rd, {18'h0, d[13:0]});
        wb(1'b0, 8'h0C, 32'h0, rd);
        check(rd, 32'h0);
        for (int i = 0; i < 40; i++) begin
            c = 14'($urandom);
            if (i < 8)
                c[12:10] = 3'(i);
            if (i == 8)
                c[12:7] = 6'b000000;
            if (i == 9)
                c[12:7] = 6'b101101;
            seq <= (i > 9) && ($urandom_range(1) == 1);
            dly <= (i % 3 == 0) ? 4'hC : 4'($urandom_range(9));
            raw_set <= '{over: (i % 5 == 1), under: (i % 5 inside {1, 2}),
                         code: 16'($urandom)};
            @(posedge clk_i);
            convert(c, i % 3 == 0);
        end
        finish_test();
    end
endmodule : aicd_config_core_test
`default_nettype wire
